//--- logic/gen_ctrl_pkg.sv
// Constants for the bridge general control register
package gen_ctrl_pkg;
   localparam logic [7:0] gen_ctrl_offset = 8'hd4;
   localparam logic [31:0] gen_ctrl_reset = 32'h8600025f;
   // Field positions
   localparam int retry_hi = 31;
   localparam int retry_lo = 30;
   localparam int link_pm_hi = 29;
   localparam int link_pm_lo = 28;
   localparam int low_swing_bit = 27;
   localparam int pm_rev_bit = 26;
   localparam int rsvd_rw_bit = 25;
   localparam int rsvd_ro_bit = 24;
   localparam int clock_pm_bit = 23;
   localparam int low_hi = 22;
   // Retry times in microseconds, one per select code
   localparam int retry_us_0 = 25;
   localparam int retry_us_1 = 1000;
   localparam int retry_us_2 = 25000;
   localparam int retry_us_3 = 50000;
   localparam int clock_mhz = 125;
   localparam logic [2:0] pm_rev_old = 3'h2;
   localparam logic [2:0] pm_rev_new = 3'h3;
endpackage

//--- logic/retry_if.sv
// Interface between control register and retry timer
`timescale 1ns/10ps
interface retry_if;
   logic [1:0] sel;
   logic start;
   logic expired;
   modport ctrl (output sel, output start, input expired);
   modport timer (input sel, input start, output expired);
endinterface

//--- logic/retry_timer.sv
// Configuration retry interval timer
`timescale 1ns/10ps
module retry_timer #(
   parameter int cnt_w = 23
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Control
   retry_if.timer rt
);
   logic [cnt_w-1:0] cnt_q, cnt_d;
   logic run_q, run_d;
   logic exp_q, exp_d;

   // Cycle count for a selected interval
   function automatic logic [cnt_w-1:0] cycles(input logic [1:0] s);
      int us;
      case (s)
         2'h0: us = gen_ctrl_pkg::retry_us_0;
         2'h1: us = gen_ctrl_pkg::retry_us_1;
         2'h2: us = gen_ctrl_pkg::retry_us_2;
         default: us = gen_ctrl_pkg::retry_us_3;
      endcase
      return cnt_w'(us * gen_ctrl_pkg::clock_mhz);
   endfunction

   // Widest interval must fit the counter
   localparam int min_w = $clog2(gen_ctrl_pkg::retry_us_3 * gen_ctrl_pkg::clock_mhz + 1);
   if (cnt_w < min_w) begin : g_narrow
      $error("retry counter too narrow");
   end

   // Count down from start, flag once interval elapsed
   always_comb begin
      cnt_d = cnt_q;
      run_d = run_q;
      exp_d = 1'b0;
      if (rt.start) begin
         cnt_d = cycles(rt.sel);
         run_d = 1'b1;
      end else if (run_q) begin
         if (cnt_q <= cnt_w'(1)) begin
            run_d = 1'b0;
            exp_d = 1'b1;
         end else begin
            cnt_d = cnt_q - cnt_w'(1);
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= '0;
         run_q <= 1'b0;
         exp_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         run_q <= run_d;
         exp_q <= exp_d;
      end
   end

   assign rt.expired = exp_q;

   // No expiry in the two cycles after a start
   no_early_a: assert property (@(posedge clock) disable iff (!rst_b)
      rt.start |=> !rt.expired [*2]) else $error("retry expired too early");
   // Shortest and longest intervals load their full counts
   load_short_a: assert property (@(posedge clock) disable iff (!rst_b)
      rt.start && rt.sel == 2'h0
      |=> cnt_q == cnt_w'(gen_ctrl_pkg::retry_us_0 * gen_ctrl_pkg::clock_mhz))
      else $error("short retry count wrong");
   load_long_a: assert property (@(posedge clock) disable iff (!rst_b)
      rt.start && rt.sel == 2'h3
      |=> cnt_q == cnt_w'(gen_ctrl_pkg::retry_us_3 * gen_ctrl_pkg::clock_mhz))
      else $error("long retry count wrong");
endmodule

//--- logic/bridge_general_control_upper.sv
// General control register, upper fields, with retry timing
// Notes on behaviour
// - 32-bit config register at 0xd4, reset value 0x8600025f.
// - Bits 31:30 select retry time: 25us, 1ms, 25ms, 50ms.
// - Retry on secondary bus whole interval before retry completion status.
// - Bits 29:28 give power-up default of link control bits 1:0.
// - Bit 27 set selects half-amplitude transmit without pre-emphasis; resets zero.
// - Bit 26 clear reports version 010 flag 0; set reports 011 flag 1.
// - Bit 24 reads zero always; writes ignored.
// - Bit 23 gives clock PM enable default: 0 gives 00, 1 gives 11.
// - Link, global and power-on reset restore all read/write fields.
`timescale 1ns/10ps
module bridge_general_control_upper (
   // Clock and resets
   input wire logic clock,
   input wire logic rst_b,
   input wire logic link_reset_b,
   input wire logic global_reset_in_b,
   // Configuration access
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_rvalid,
   // Retry engine
   input wire logic retry_req,
   input wire logic retry_ack,
   output logic retry_status,
   // Derived controls
   output logic [1:0] link_pm_default,
   output logic [1:0] clock_pm_enable,
   output logic tx_low_swing,
   output logic [2:0] pm_revision_code,
   output logic no_soft_reset
);
   logic [31:0] reg_q, reg_d;
   logic [31:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic pend_q, pend_d;
   logic rstat_q, rstat_d;
   logic soft_rst;
   logic [1:0] lpm_d, cpm_d;
   logic swing_d;
   logic [2:0] rev_d;
   logic nsr_d;
   retry_if rt ();

   // Decode of this register's offset
   function automatic logic addr_hit(input logic [7:0] a);
      return a == gen_ctrl_pkg::gen_ctrl_offset;
   endfunction

   // Link or global reset returns fields synchronously
   assign soft_rst = !link_reset_b || !global_reset_in_b;

   // Open issue: whole-word reset sets bit 25 and clears bits 29:28,
   // unlike the per-field defaults; the whole-word pattern is kept
   // Writes in a soft reset cycle are lost on purpose
   // Byte-enabled write path
   always_comb begin
      reg_d = reg_q;
      if (soft_rst) begin
         reg_d = gen_ctrl_pkg::gen_ctrl_reset;
      end else if (cfg_wr && addr_hit(cfg_addr)) begin
         for (int b = 0; b < 4; b++) begin
            if (cfg_be[b]) reg_d[b*8 +: 8] = cfg_wdata[b*8 +: 8];
         end
      end
      reg_d[gen_ctrl_pkg::rsvd_ro_bit] = 1'b0;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         reg_q <= gen_ctrl_pkg::gen_ctrl_reset;
      end else begin
         reg_q <= reg_d;
      end
   end

   // Read path, unmapped offsets read zero
   // Read beside a write returns the old value
   always_comb begin
      rvalid_d = cfg_rd;
      rdata_d = '0;
      if (cfg_rd && addr_hit(cfg_addr)) begin
         rdata_d = reg_q;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= '0;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // Retry timer control
   assign rt.sel = reg_q[gen_ctrl_pkg::retry_hi:gen_ctrl_pkg::retry_lo];
   assign rt.start = retry_req && !pend_q;

   retry_timer #(.cnt_w(23)) u_timer (
      .clock(clock),
      .rst_b(rst_b),
      .rt(rt)
   );

   // Retry completion status only after interval elapsed
   always_comb begin
      pend_d = pend_q;
      rstat_d = rstat_q;
      if (rt.start) begin
         pend_d = 1'b1;
         rstat_d = 1'b0;
      end else if (pend_q && rt.expired) begin
         pend_d = 1'b0;
         rstat_d = 1'b1;
      end else if (retry_ack) begin
         rstat_d = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pend_q <= 1'b0;
         rstat_q <= 1'b0;
      end else begin
         pend_q <= pend_d;
         rstat_q <= rstat_d;
      end
   end

   // Next values of the derived controls
   always_comb begin
      lpm_d = reg_d[gen_ctrl_pkg::link_pm_hi:gen_ctrl_pkg::link_pm_lo];
      cpm_d = {2{reg_d[gen_ctrl_pkg::clock_pm_bit]}};
      swing_d = reg_d[gen_ctrl_pkg::low_swing_bit];
      rev_d = reg_d[gen_ctrl_pkg::pm_rev_bit] ? gen_ctrl_pkg::pm_rev_new
                                              : gen_ctrl_pkg::pm_rev_old;
      nsr_d = reg_d[gen_ctrl_pkg::pm_rev_bit];
   end

   // Registered derived controls
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         link_pm_default <= '0;
         clock_pm_enable <= '0;
         tx_low_swing <= 1'b0;
         pm_revision_code <= gen_ctrl_pkg::pm_rev_new;
         no_soft_reset <= 1'b1;
      end else begin
         link_pm_default <= lpm_d;
         clock_pm_enable <= cpm_d;
         tx_low_swing <= swing_d;
         pm_revision_code <= rev_d;
         no_soft_reset <= nsr_d;
      end
   end

   assign cfg_rdata = rdata_q;
   assign cfg_rvalid = rvalid_q;
   assign retry_status = rstat_q;

   // Bit 24 always zero on read
   rsvd_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
      cfg_rvalid |-> !cfg_rdata[gen_ctrl_pkg::rsvd_ro_bit])
      else $error("reserved bit read as one");
   // Retry status needs prior pending interval
   retry_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
      $rose(retry_status) |-> $past(pend_q))
      else $error("retry status without wait");
   // Low swing follows bit 27
   low_swing_a: assert property (@(posedge clock) disable iff (!rst_b)
      tx_low_swing == reg_q[gen_ctrl_pkg::low_swing_bit])
      else $error("low swing mismatch");
   // Revision code and flag both follow bit 26
   pm_rev_a: assert property (@(posedge clock) disable iff (!rst_b)
      pm_revision_code == (no_soft_reset ? gen_ctrl_pkg::pm_rev_new : gen_ctrl_pkg::pm_rev_old)
      && no_soft_reset == reg_q[gen_ctrl_pkg::pm_rev_bit])
      else $error("pm revision mismatch");
   // Clock PM default both bits equal bit 23
   clock_pm_a: assert property (@(posedge clock) disable iff (!rst_b)
      clock_pm_enable == {2{reg_q[gen_ctrl_pkg::clock_pm_bit]}})
      else $error("clock pm default mismatch");
   // Link PM default tracks bits 29:28
   link_pm_a: assert property (@(posedge clock) disable iff (!rst_b)
      link_pm_default == reg_q[gen_ctrl_pkg::link_pm_hi:gen_ctrl_pkg::link_pm_lo])
      else $error("link pm default mismatch");
   // Soft reset restores value
   soft_reset_a: assert property (@(posedge clock) disable iff (!rst_b)
      soft_rst |=> reg_q == gen_ctrl_pkg::gen_ctrl_reset)
      else $error("reset value not restored");
   // Read returns register in one cycle
   read_data_a: assert property (@(posedge clock) disable iff (!rst_b)
      cfg_rd && addr_hit(cfg_addr) && !cfg_wr |=> cfg_rdata == $past(reg_q))
      else $error("read data wrong");
   // Every read answered one cycle later
   rvalid_pulse_a: assert property (@(posedge clock) disable iff (!rst_b)
      cfg_rd |=> cfg_rvalid)
      else $error("read not answered");
   // No answer without a read
   rvalid_idle_a: assert property (@(posedge clock) disable iff (!rst_b)
      !cfg_rd |=> !cfg_rvalid)
      else $error("stray read answer");
   // Other offsets read zero
   unmapped_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
      cfg_rd && !addr_hit(cfg_addr) |=> cfg_rdata == '0)
      else $error("unmapped read not zero");
   // Upper byte write lands in bits 31:25
   write_lane_a: assert property (@(posedge clock) disable iff (!rst_b)
      cfg_wr && addr_hit(cfg_addr) && cfg_be[3] && !soft_rst
      |=> reg_q[gen_ctrl_pkg::retry_hi:gen_ctrl_pkg::rsvd_rw_bit]
          == $past(cfg_wdata[gen_ctrl_pkg::retry_hi:gen_ctrl_pkg::rsvd_rw_bit]))
      else $error("write did not land");
   // Register holds without write or reset
   reg_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
      !cfg_wr && !soft_rst |=> $stable(reg_q))
      else $error("register changed unasked");
   // Start opens an interval and clears status
   start_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
      rt.start |=> !retry_status && pend_q)
      else $error("retry start not taken");
   // No status while the interval runs
   no_status_a: assert property (@(posedge clock) disable iff (!rst_b)
      pend_q && !rt.expired |=> pend_q && !retry_status)
      else $error("retry status during interval");
   // Status stands until consumed
   status_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
      retry_status && !retry_ack && !rt.start |=> retry_status)
      else $error("retry status dropped early");
   // Consumption clears status
   ack_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
      retry_status && retry_ack && !pend_q |=> !retry_status)
      else $error("retry status not cleared");
endmodule

//--- testbench/retry_consumer.sv
// Upstream consumer of retry completions, acks after a delay
`timescale 1ns/10ps
module retry_consumer #(
   parameter int ack_delay = 3
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Completion handshake
   input wire logic retry_status,
   output logic retry_ack
);
   int cnt;
   // Consume the retry completion once it has stood ack_delay cycles
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 0;
         retry_ack <= 1'b0;
      end else begin
         retry_ack <= retry_status && cnt == ack_delay - 1 && !retry_ack;
         cnt <= retry_status ? cnt + 1 : 0;
      end
   end
endmodule

//--- testbench/bridge_general_control_upper_bench.sv
// Bench for the general control register upper fields
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module bridge_general_control_upper_bench;
   logic clock, rst_b, link_reset_b, global_reset_in_b, cfg_wr, cfg_rd, retry_req;
   logic [7:0] cfg_addr;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata, rd;
   logic cfg_rvalid, retry_ack, retry_status, tx_low_swing, no_soft_reset;
   logic [1:0] link_pm_default, clock_pm_enable;
   logic [2:0] pm_revision_code;
   int n_errors = 0;
   int check_count = 0;
   int k;
   typedef struct {
      logic [3:0] be; logic [31:0] wd; logic [8:0] up;
      logic [1:0] lpm; logic [1:0] cpm; logic tx; logic [2:0] rev;
   } row_s;
   // Byte enables, write data, then bits 31:23 and derived outputs expected
   row_s rows [4] = '{'{4'h8, 32'h3d000000, 9'h078, 2'h3, 2'h0, 1'b1, 3'h3},
      '{4'hc, 32'h49800000, 9'h091, 2'h0, 2'h3, 1'b1, 3'h2},
      '{4'h4, 32'h00000000, 9'h090, 2'h0, 2'h0, 1'b1, 3'h2},
      '{4'h0, 32'hffffffff, 9'h090, 2'h0, 2'h0, 1'b1, 3'h2}};
   // Design and completion consumer
   bridge_general_control_upper uut (.clock, .rst_b, .link_reset_b, .global_reset_in_b,
      .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rvalid, .retry_req,
      .retry_ack, .retry_status, .link_pm_default, .clock_pm_enable, .tx_low_swing,
      .pm_revision_code, .no_soft_reset);
   retry_consumer partner (.clock, .rst_b, .retry_status, .retry_ack);
   // Clock and watchdog
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      #200000;
      n_errors++;
      stop_test();
   end
   task automatic stop_test();
      $display("Errors %0d of %0d checks", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // One write, taken at the second edge
   task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(posedge clock);
      cfg_wr <= 1'b1;
      cfg_addr <= a;
      cfg_be <= be;
      cfg_wdata <= d;
      @(posedge clock);
      cfg_wr <= 1'b0;
      #1;
   endtask
   // One read, data sampled in the valid cycle
   task automatic cfg_read(input logic [7:0] a);
      @(posedge clock);
      cfg_rd <= 1'b1;
      cfg_addr <= a;
      @(posedge clock);
      cfg_rd <= 1'b0;
      #1;
      rd = cfg_rdata;
      `CHK("rvalid", 1'b1, cfg_rvalid)
   endtask
   // Main sequence
   initial begin
      {rst_b, cfg_wr, cfg_rd, retry_req, cfg_addr, cfg_be, cfg_wdata} = '0;
      {link_reset_b, global_reset_in_b} = 2'h3;
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      #1;
      `CHK("lpm", 2'h0, link_pm_default)
      `CHK("cpm", 2'h0, clock_pm_enable)
      `CHK("tx", 1'b0, tx_low_swing)
      `CHK("rev", 3'h3, pm_revision_code)
      `CHK("nsr", 1'b1, no_soft_reset)
      cfg_read(8'hd4);
      `CHK("reset", 32'h8600025f, rd)
      foreach (rows[i]) begin
         cfg_write(8'hd4, rows[i].be, rows[i].wd);
         `CHK("lpm", rows[i].lpm, link_pm_default)
         `CHK("cpm", rows[i].cpm, clock_pm_enable)
         `CHK("tx", rows[i].tx, tx_low_swing)
         `CHK("rev", rows[i].rev, pm_revision_code)
         `CHK("nsr", rows[i].rev[0], no_soft_reset)
         cfg_read(8'hd4);
         `CHK("upper", rows[i].up, rd[31:23])
      end
      // Unmapped offset reads zero and takes no write
      cfg_write(8'hd0, 4'hf, 32'hffffffff);
      cfg_read(8'hd0);
      `CHK("unmapped", 32'h0, rd)
      cfg_read(8'hd4);
      `CHK("upper", 9'h090, rd[31:23])
      // Link reset then global reset restore defaults
      for (int i = 0; i < 2; i++) begin
         cfg_write(8'hd4, 4'hc, 32'h49800000);
         @(posedge clock);
         if (i == 0) link_reset_b <= 1'b0;
         else global_reset_in_b <= 1'b0;
         // A write during the reset is lost
         cfg_write(8'hd4, 4'hf, 32'h49800000);
         @(posedge clock);
         {link_reset_b, global_reset_in_b} <= 2'h3;
         cfg_read(8'hd4);
         `CHK("rst", 32'h8600025f, rd)
         `CHK("tx", 1'b0, tx_low_swing)
      end
      // Shortest retry interval, status one edge after the count ends
      cfg_write(8'hd4, 4'h8, 32'h04000000);
      @(posedge clock);
      retry_req <= 1'b1;
      @(posedge clock);
      retry_req <= 1'b0;
      k = 0;
      do begin
         @(posedge clock);
         #1;
         k++;
      end while (retry_status !== 1'b1 && k < 4000);
      `CHK("retry", gen_ctrl_pkg::retry_us_0 * gen_ctrl_pkg::clock_mhz + 1, k)
      repeat (6) @(posedge clock);
      #1;
      `CHK("ackd", 1'b0, retry_status)
      // Longer intervals not finished 3200 cycles after start; power-on reset clears them
      for (int s = 1; s < 4; s++) begin
         cfg_write(8'hd4, 4'h8, {s[1:0], 6'h04, 24'h0});
         @(posedge clock);
         retry_req <= 1'b1;
         @(posedge clock);
         retry_req <= 1'b0;
         repeat (3200) @(posedge clock);
         #1;
         `CHK("early", 1'b0, retry_status)
         @(posedge clock);
         rst_b <= 1'b0;
         repeat (2) @(posedge clock);
         rst_b <= 1'b1;
         #1;
         `CHK("por_stat", 1'b0, retry_status)
         `CHK("por_rev", 3'h3, pm_revision_code)
         cfg_read(8'hd4);
         `CHK("por", 32'h8600025f, rd)
      end
      stop_test();
   end
endmodule
